// ---- verilog/psc_defines.vh ----
// Offsets, command codes, reset values and timing for the strobe and clock command block
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// Register byte offsets
`define PSC_OFF_CMD        12'h000
`define PSC_OFF_EXT_LO     12'h004
`define PSC_OFF_EXT_HI     12'h008
`define PSC_OFF_STATUS     12'h00C
`define PSC_OFF_PHASE      12'h010

// Command word fields
`define PSC_CODE_LSB       0
`define PSC_LOW_LSB        8
`define PSC_HIGH_LSB       16

// Status word fields
`define PSC_ST_PRESC_LSB   0
`define PSC_ST_EN_LSB      8
`define PSC_ST_CLK_LSB     12
`define PSC_ST_BUSY_BIT    16

// Sub command codes
`define PSC_SC_STB_LOW     8'h0E
`define PSC_SC_BLK_HIGH    8'h0F
`define PSC_SC_BLK_LOW     8'h10
`define PSC_SC_LATCH64     8'h11
`define PSC_SC_PRESCALE    8'h13
`define PSC_SC_CLK_EN      8'h14
`define PSC_SC_DUTY0       8'h15
`define PSC_SC_DUTY1       8'h16
`define PSC_SC_DUTY3       8'h17
`define PSC_SC_DUTY2       8'h18
`define PSC_SC_SYNC        8'h19
`define PSC_SC_PHASE0      8'h1A
`define PSC_SC_PHASE3      8'h1D

// Reset values
`define PSC_PRESC_RST      8'h0A
`define PSC_DUTY_RST       8'h01

// Timing
`define PSC_CLK_NS         8
`define PSC_STB_NS         40
`define PSC_STB_CYC        ((`PSC_STB_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_PHASE_STEP_NS  10000000
`define PSC_PHASE_CYC      (`PSC_PHASE_STEP_NS / `PSC_CLK_NS)
`define PSC_BASE_NS        1000
`define PSC_BASE_CYC       (`PSC_BASE_NS / `PSC_CLK_NS)
`define PSC_DLY_TICK_CYC   125

`endif

// ---- verilog/psc_clk_chan.v ----
// One clock generator channel with sync preset and initial phase delay
`timescale 1ns/1ps
module psc_clk_chan (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       tick,
  input  wire       phase_tick,
  input  wire       enable,
  input  wire [7:0] high_phase_count,
  input  wire [7:0] low_phase_count,
  input  wire       sync,
  input  wire       sync_level,
  input  wire [7:0] sync_delay,
  output reg        clk_out_r
);

  reg [7:0] cnt_r;
  reg [7:0] dly_r;
  reg       wait_r;

  // Phase counting, sync restart and initial delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_out_r <= 1'b0;
      cnt_r     <= 8'h01;
      dly_r     <= 8'h00;
      wait_r    <= 1'b0;
    end else if (sync) begin
      clk_out_r <= sync_level;
      cnt_r     <= sync_level ? high_phase_count : low_phase_count;
      dly_r     <= sync_delay;
      wait_r    <= (sync_delay != 8'h00);
    end else if (wait_r) begin
      if (phase_tick) begin
        dly_r  <= dly_r - 8'h01;
        wait_r <= (dly_r != 8'h01);
      end
    end else if (enable && tick) begin
      if (cnt_r <= 8'h01) begin
        clk_out_r <= ~clk_out_r;
        cnt_r     <= clk_out_r ? low_phase_count : high_phase_count;
      end else begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

endmodule

// ---- verilog/psc_cmd_top.v ----
// Command decoder: port strobes, latch writes and four channel clock generator
`timescale 1ns/1ps
`include "psc_defines.vh"

module psc_cmd_top #(
  parameter PHASE_CYC = `PSC_PHASE_CYC,
  parameter DLY_TICK  = `PSC_DLY_TICK_CYC,
  parameter BASE_CYC  = `PSC_BASE_CYC,
  parameter STB_CYC   = `PSC_STB_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [7:0]  port_zero_value,
  output reg  [7:0]  port1_out,
  output reg  [2:0]  latch_addr,
  output reg         latch_wr_n
);

  localparam S_IDLE = 3'd0;
  localparam S_PUT  = 3'd1;
  localparam S_ACT  = 3'd2;
  localparam S_REL  = 3'd3;
  localparam S_DLY  = 3'd4;

  reg  [2:0]  state_r;
  reg  [23:0] cnt_r;
  reg  [2:0]  idx_r;
  reg  [7:0]  code_r;
  reg  [7:0]  low_param_byte;
  reg  [7:0]  high_param_byte;
  reg  [63:0] payload_block;
  reg  [7:0]  strobe_r;
  reg  [7:0]  presc_r;
  reg  [3:0]  clk_en_r;
  reg  [63:0] duty_r;
  reg  [31:0] phase_r;
  reg  [3:0]  sync_r;
  reg  [3:0]  sync_lvl_r;
  reg  [31:0] sync_dly_r;
  reg  [15:0] base_cnt_r;
  reg  [7:0]  pre_cnt_r;
  reg         tick_r;
  reg  [23:0] ph_cnt_r;
  reg         ph_tick_r;
  wire [3:0]  chan_out;
  wire        acc;
  wire        hit_cmd;
  wire        busy;
  wire [7:0]  sub_command_code;
  wire [7:0]  cur_byte;

  // Strobe active level: high for code 15, low otherwise
  function act_high;
    input [7:0] code;
    begin
      act_high = (code == `PSC_SC_BLK_HIGH);
    end
  endfunction

  // Address decode shared by read and write paths
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `PSC_OFF_CMD) || (a == `PSC_OFF_EXT_LO) || (a == `PSC_OFF_EXT_HI) ||
               (a == `PSC_OFF_STATUS) || (a == `PSC_OFF_PHASE);
    end
  endfunction

  assign busy             = (state_r != S_IDLE);
  assign acc              = psel & penable & pready;
  assign hit_cmd          = acc & pwrite & (paddr == `PSC_OFF_CMD);
  assign sub_command_code = pwdata[`PSC_CODE_LSB +: 8];
  assign cur_byte         = payload_block[{idx_r, 3'b000} +: 8];

  // APB answer; command writes stall while a sequence runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready &
                 ~(pwrite && paddr == `PSC_OFF_CMD && busy);
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
      case (paddr)
        `PSC_OFF_CMD:    prdata <= {8'h00, high_param_byte, low_param_byte, code_r};
        `PSC_OFF_EXT_LO: prdata <= payload_block[31:0];
        `PSC_OFF_EXT_HI: prdata <= payload_block[63:32];
        `PSC_OFF_STATUS: prdata <= {15'h0000, busy, chan_out, clk_en_r, presc_r};
        `PSC_OFF_PHASE:  prdata <= phase_r;
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Prescaled timebase and 10ms phase step
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_cnt_r <= 16'h0000;
      pre_cnt_r  <= 8'h00;
      tick_r     <= 1'b0;
      ph_cnt_r   <= 24'h00_0000;
      ph_tick_r  <= 1'b0;
    end else begin
      tick_r    <= 1'b0;
      ph_tick_r <= 1'b0;
      if (base_cnt_r == BASE_CYC[15:0] - 16'h0001) begin
        base_cnt_r <= 16'h0000;
        if (pre_cnt_r + 8'h01 >= presc_r) begin
          pre_cnt_r <= 8'h00;
          tick_r    <= 1'b1;
        end else begin
          pre_cnt_r <= pre_cnt_r + 8'h01;
        end
      end else begin
        base_cnt_r <= base_cnt_r + 16'h0001;
      end
      if (hit_cmd && sub_command_code == `PSC_SC_SYNC) begin
        ph_cnt_r <= 24'h00_0000;
      end else if (ph_cnt_r == PHASE_CYC[23:0] - 24'h00_0001) begin
        ph_cnt_r  <= 24'h00_0000;
        ph_tick_r <= 1'b1;
      end else begin
        ph_cnt_r <= ph_cnt_r + 24'h00_0001;
      end
    end
  end

  // Register writes and immediate clock commands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_r          <= 8'h00;
      low_param_byte  <= 8'h00;
      high_param_byte <= 8'h00;
      payload_block   <= 64'h0000_0000_0000_0000;
      presc_r         <= `PSC_PRESC_RST;
      clk_en_r        <= 4'h0;
      duty_r          <= {8{`PSC_DUTY_RST}};
      phase_r         <= 32'h0000_0000;
      sync_r          <= 4'h0;
      sync_lvl_r      <= 4'h0;
      sync_dly_r      <= 32'h0000_0000;
    end else begin
      sync_r <= 4'h0;
      if (acc && pwrite && paddr == `PSC_OFF_EXT_LO) begin
        payload_block[31:0] <= pwdata;
      end
      if (acc && pwrite && paddr == `PSC_OFF_EXT_HI) begin
        payload_block[63:32] <= pwdata;
      end
      if (hit_cmd) begin
        code_r          <= sub_command_code;
        low_param_byte  <= pwdata[`PSC_LOW_LSB +: 8];
        high_param_byte <= pwdata[`PSC_HIGH_LSB +: 8];
        case (sub_command_code)
          `PSC_SC_PRESCALE: begin
            // zero is not a legal value
            if (pwdata[`PSC_LOW_LSB +: 8] != 8'h00) begin
              presc_r <= pwdata[`PSC_LOW_LSB +: 8];
            end
          end
          `PSC_SC_CLK_EN: begin
            clk_en_r <= (clk_en_r | pwdata[`PSC_HIGH_LSB +: 4]) &
                        ~pwdata[`PSC_LOW_LSB +: 4];
          end
          `PSC_SC_DUTY0: duty_r[15:0]  <= pwdata[`PSC_LOW_LSB +: 16];
          `PSC_SC_DUTY1: duty_r[31:16] <= pwdata[`PSC_LOW_LSB +: 16];
          `PSC_SC_DUTY2: duty_r[47:32] <= pwdata[`PSC_LOW_LSB +: 16];
          `PSC_SC_DUTY3: duty_r[63:48] <= pwdata[`PSC_LOW_LSB +: 16];
          `PSC_SC_SYNC: begin
            sync_r     <= pwdata[`PSC_LOW_LSB +: 4];
            sync_lvl_r <= pwdata[`PSC_HIGH_LSB +: 4];
            sync_dly_r <= phase_r;
            phase_r    <= 32'h0000_0000;
          end
          default: begin
            if (sub_command_code >= `PSC_SC_PHASE0 && sub_command_code <= `PSC_SC_PHASE3) begin
              phase_r[{sub_command_code[1:0] - 2'd2, 3'b000} +: 8] <= pwdata[`PSC_LOW_LSB +: 8];
            end
          end
        endcase
      end
    end
  end

  // Strobe and latch sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r         <= S_IDLE;
      cnt_r           <= 24'h00_0000;
      idx_r           <= 3'd0;
      strobe_r        <= 8'h00;
      port_zero_value <= 8'h00;
      latch_addr      <= 3'd0;
      latch_wr_n      <= 1'b1;
    end else begin
      case (state_r)
        S_IDLE: begin
          idx_r <= 3'd0;
          cnt_r <= STB_CYC[23:0];
          if (hit_cmd) begin
            case (sub_command_code)
              `PSC_SC_STB_LOW: begin
                port_zero_value <= pwdata[`PSC_LOW_LSB +: 8];
                state_r         <= S_PUT;
              end
              `PSC_SC_BLK_HIGH, `PSC_SC_BLK_LOW, `PSC_SC_LATCH64: begin
                state_r <= S_PUT;
              end
              default: state_r <= S_IDLE;
            endcase
          end
        end
        S_PUT: begin
          if (code_r != `PSC_SC_STB_LOW) begin
            port_zero_value <= cur_byte;
          end
          if (code_r != `PSC_SC_LATCH64) begin
            strobe_r <= act_high(code_r) ? 8'h00 : high_param_byte;
          end
          latch_addr <= idx_r;
          cnt_r      <= cnt_r - 24'h00_0001;
          if (cnt_r == 24'h00_0001) begin
            cnt_r   <= STB_CYC[23:0];
            state_r <= S_ACT;
          end
        end
        S_ACT: begin
          if (code_r == `PSC_SC_LATCH64) begin
            latch_wr_n <= 1'b0;
          end else begin
            strobe_r <= act_high(code_r) ? high_param_byte : 8'h00;
          end
          cnt_r <= cnt_r - 24'h00_0001;
          if (cnt_r == 24'h00_0001) begin
            cnt_r   <= STB_CYC[23:0];
            state_r <= S_REL;
          end
        end
        S_REL: begin
          latch_wr_n <= 1'b1;
          strobe_r   <= act_high(code_r) ? 8'h00 : high_param_byte;
          cnt_r      <= cnt_r - 24'h00_0001;
          if (cnt_r == 24'h00_0001) begin
            cnt_r   <= {16'h0000, low_param_byte} * {8'h00, DLY_TICK[15:0]};
            state_r <= (code_r == `PSC_SC_BLK_HIGH || code_r == `PSC_SC_BLK_LOW) ? S_DLY :
                       (code_r == `PSC_SC_LATCH64 && idx_r != 3'd7) ? S_PUT : S_IDLE;
            if (code_r == `PSC_SC_LATCH64) begin
              cnt_r <= STB_CYC[23:0];
              idx_r <= idx_r + 3'd1;
            end
          end
        end
        S_DLY: begin
          if (cnt_r != 24'h00_0000) begin
            cnt_r <= cnt_r - 24'h00_0001;
          end else begin
            cnt_r   <= STB_CYC[23:0];
            idx_r   <= idx_r + 3'd1;
            state_r <= (idx_r == 3'd7) ? S_IDLE : S_PUT;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Port 1: clock channels override strobe levels on pins 0-3
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_out <= 8'h00;
    end else begin
      port1_out <= {strobe_r[7:4], (chan_out & clk_en_r) | (strobe_r[3:0] & ~clk_en_r)};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      psc_clk_chan u_chan (
        .pclk             (pclk),
        .presetn          (presetn),
        .tick             (tick_r),
        .phase_tick       (ph_tick_r),
        .enable           (clk_en_r[g]),
        .high_phase_count (duty_r[g*16 +: 8]),
        .low_phase_count  (duty_r[g*16+8 +: 8]),
        .sync             (sync_r[g]),
        .sync_level       (sync_lvl_r[g]),
        .sync_delay       (sync_dly_r[g*8 +: 8]),
        .clk_out_r        (chan_out[g])
      );
    end
  endgenerate

endmodule

// ---- verification/psc_host.sv ----
// Host model issuing command packets over APB
`timescale 1ns/1ps
module psc_host (
  input  wire         pclk,
  input  wire         pready,
  input  wire         pslverr,
  input  wire  [31:0] prdata,
  output logic        psel = 1'b0,
  output logic        penable = 1'b0,
  output logic        pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0
);
  // One transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic t);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 4000);
    q = prdata;
    e = pslverr;
    t = (n >= 4000);
    // Release at the answering edge; idle lines scrambled
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ---- verification/psc_cmd_properties.sv ----
// Port assertions for the command block
`timescale 1ns/1ps
module psc_cmd_properties #(
  parameter STB_CYC = 5
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [7:0]  port_zero_value,
  input wire [2:0]  latch_addr,
  input wire        latch_wr_n
);
  reg [7:0] low_cnt_r;
  default clocking ck @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Cycles spent with the latch strobe low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      low_cnt_r <= 8'h00;
    else if (latch_wr_n)
      low_cnt_r <= 8'h00;
    else
      low_cnt_r <= low_cnt_r + 8'h01;
  end
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready too long");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
  property p_ready_wait;
    pready |-> psel && penable && $past(penable);
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready early");
  property p_unmapped;
    pready && paddr > 12'h010 |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
  property p_cmd_held;
    !latch_wr_n |-> !(pready && pwrite && paddr == 12'h000);
  endproperty
  a_cmd_held: assert property (p_cmd_held) else $error("command taken busy");
  property p_latch_low;
    $rose(latch_wr_n) |-> low_cnt_r == STB_CYC;
  endproperty
  a_latch_low: assert property (p_latch_low) else $error("latch pulse width");
  property p_latch_hold;
    !latch_wr_n && $past(!latch_wr_n) |-> $stable(port_zero_value) && $stable(latch_addr);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch data moved");
  property p_latch_high;
    $rose(latch_wr_n) |=> latch_wr_n [*4];
  endproperty
  a_latch_high: assert property (p_latch_high) else $error("latch gap short");
endmodule
bind psc_cmd_top psc_cmd_properties #(.STB_CYC(STB_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_zero_value(port_zero_value), .latch_addr(latch_addr), .latch_wr_n(latch_wr_n)
);

// ---- verification/testbench.sv ----
// Self-checking bench for the strobe and clock command block
`timescale 1ns/1ps
`include "psc_defines.vh"
module testbench;
  localparam int STB = 5;
  localparam int DLY = 2;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  wire         psel, penable, pwrite, pready, pslverr, latch_wr_n;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata;
  wire  [7:0]  port_zero_value, port1_out;
  wire  [2:0]  latch_addr;
  logic [31:0] q;
  logic        e;
  int          n, hi, lo;
  int          err_total = 0;
  int          comparisons = 0;
  logic [63:0] ext = 64'h8877665544332211;
  // Clock at 125 MHz
  always #4 pclk = ~pclk;
  psc_cmd_top #(.PHASE_CYC(20), .DLY_TICK(DLY), .BASE_CYC(2), .STB_CYC(STB)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_zero_value(port_zero_value), .port1_out(port1_out), .latch_addr(latch_addr),
    .latch_wr_n(latch_wr_n));
  psc_host host (
    .pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic print_verdict;
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compare and tally
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus access; a hung access ends the run
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic t;
    @(posedge pclk);
    host.xfer(w, a, d, q, e, t);
    chk(t, 1'b0);
    if (t) print_verdict;
  endtask
  // Wait for strobe and port 1 under a mask, counting cycles
  task automatic wt(input logic [8:0] m, input logic [8:0] v);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((({latch_wr_n, port1_out} & m) !== v) && n < 4000);
    chk(n >= 4000, 1'b0);
    if (n >= 4000) print_verdict;
  endtask
  task automatic t_status;
    acc(0, `PSC_OFF_STATUS, 0);
    chk(q[7:0], 8'h0A);
    acc(1, 12'h020, 32'hFFFFFFFF);
    acc(0, 12'h020, 0);
    chk({e, q}, {1'b1, 32'h0});
  endtask
  task automatic t_block(input logic [7:0] code, input logic act);
    acc(1, `PSC_OFF_EXT_LO, ext[31:0]);
    acc(1, `PSC_OFF_EXT_HI, ext[63:32]);
    acc(1, `PSC_OFF_CMD, {16'h0030, 8'h03, code});
    wt(9'h030, act ? 9'h000 : 9'h030);
    for (int i = 0; i < 8; i++) begin
      wt(9'h030, act ? 9'h030 : 9'h000);
      if (i > 0) chk(n >= STB + 3 * DLY, 1'b1);
      wt(9'h030, act ? 9'h000 : 9'h030);
      chk(port_zero_value, ext[8*i +: 8]);
    end
  endtask
  task automatic t_strobe;
    acc(1, `PSC_OFF_CMD, {16'h0030, 8'hA5, `PSC_SC_STB_LOW});
    wt(9'h030, 9'h000);
    chk(port_zero_value, 8'hA5);
    wt(9'h030, 9'h030);
  endtask
  task automatic t_latch;
    acc(1, `PSC_OFF_CMD, {24'h0, `PSC_SC_LATCH64});
    for (int i = 0; i < 8; i++) begin
      wt(9'h100, 9'h000);
      chk({latch_addr, port_zero_value}, {i[2:0], ext[8*i +: 8]});
      wt(9'h100, 9'h100);
    end
  endtask
  // High and low widths of one channel in clock cycles
  task automatic meas(input int p);
    logic [8:0] m;
    m = 9'h001 << p;
    wt(m, m);
    wt(m, 9'h000);
    wt(m, m);
    wt(m, 9'h000);
    hi = n;
    wt(m, m);
    lo = n;
  endtask
  task automatic t_clocks;
    logic [7:0] dc [4];
    dc = '{`PSC_SC_DUTY0, `PSC_SC_DUTY1, `PSC_SC_DUTY2, `PSC_SC_DUTY3};
    acc(1, `PSC_OFF_CMD, {16'h0006, 8'h03, `PSC_SC_CLK_EN});
    acc(0, `PSC_OFF_STATUS, 0);
    chk(q[11:8], 4'h4);
    acc(1, `PSC_OFF_CMD, {16'h000F, 8'h00, `PSC_SC_CLK_EN});
    acc(1, `PSC_OFF_CMD, {16'h0000, 8'h01, `PSC_SC_PRESCALE});
    for (int p = 0; p < 4; p++) begin
      acc(1, `PSC_OFF_CMD, {16'h0003, 8'h02, dc[p]});
      meas(p);
      chk({hi, lo}, {32'h4, 32'h6});
    end
    acc(1, `PSC_OFF_CMD, {16'h0000, 8'h02, `PSC_SC_PRESCALE});
    acc(1, `PSC_OFF_CMD, {16'h0000, 8'h00, `PSC_SC_PRESCALE});
    acc(0, `PSC_OFF_STATUS, 0);
    chk(q[7:0], 8'h02);
    meas(0);
    chk(hi, 32'h8);
  endtask
  task automatic t_sync;
    acc(1, `PSC_OFF_CMD, {16'h0000, 8'h01, `PSC_SC_PHASE0});
    acc(1, `PSC_OFF_CMD, {16'h0000, 8'h05, `PSC_SC_PHASE3});
    acc(0, `PSC_OFF_PHASE, 0);
    chk(q, 32'h05000001);
    acc(1, `PSC_OFF_CMD, {16'h0001, 8'h01, `PSC_SC_SYNC});
    // Preset reaches the pin two edges after the command
    repeat (2) @(negedge pclk);
    repeat (12) begin
      @(negedge pclk);
      chk(port1_out[0], 1'b1);
    end
    wt(9'h001, 9'h000);
    chk(n > 10 && n < 32, 1'b1);
    acc(0, `PSC_OFF_PHASE, 0);
    chk(q, 32'h0);
  endtask
  // Reset, then the scenarios
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_status;
    t_block(`PSC_SC_BLK_HIGH, 1'b1);
    t_block(`PSC_SC_BLK_LOW, 1'b0);
    t_strobe;
    t_latch;
    t_clocks;
    t_sync;
    print_verdict;
  end
endmodule
